// ==== hw/pwr_seq_pkg.sv ====
// Constants and state types for the modem power-state sequencer
package pwr_seq_pkg;

    // System clock rate
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;

    // Least low time on the on/off-wake pin, in milliseconds
    localparam int unsigned WAKE_MIN_MS     = 5000;
    localparam int unsigned WAKE_MIN_CYC    = (WAKE_MIN_MS * (CLK_HZ / 1000));

    // Least graceful power-off time, in milliseconds
    localparam int unsigned GRACE_MIN_MS    = 1000;
    localparam int unsigned GRACE_MIN_CYC   = (GRACE_MIN_MS * (CLK_HZ / 1000));

    // Least low time that counts as an on/off power-off pulse, milliseconds
    localparam int unsigned OFF_PULSE_MS    = 1000;
    localparam int unsigned OFF_PULSE_CYC   = (OFF_PULSE_MS * (CLK_HZ / 1000));

    // Sleep duty cycle of the main processor, in cycles
    localparam int unsigned SLEEP_PERIOD_CYC = 1000;
    localparam int unsigned SLEEP_ON_CYC     = 100;

    // Width of the timing counters
    localparam int unsigned CNT_W           = 32;

    // Power states, Gray coded along off, on, sleep, deep sleep
    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_ON       = 3'b001,
        ST_SLEEP    = 3'b011,
        ST_PSM      = 3'b010,
        ST_GRACE    = 3'b110,
        ST_HALT     = 3'b111,
        ST_FAST     = 3'b101
    } pwr_state_type;

endpackage

// ==== hw/wake_if.sv ====
// Interface carrying the on/off-wake pin low-time measurement
`timescale 1ns/1ps
interface wake_if;
    logic       pin_low;    // Synchronised pin level, high when pin is low
    logic       long_low;   // Pin low for at least the wake minimum
    logic       off_low;    // Pin low for at least the power-off pulse
    logic       released;   // One-cycle pulse when the pin goes back high
    logic       was_long;   // With released: the low phase met wake minimum

    modport meas (input pin_low, output long_low, off_low, released, was_long);
    modport ctrl (output pin_low, input long_low, off_low, released, was_long);
endinterface

// ==== hw/wake_timer.sv ====
// Low-time meter for the on/off-wake pin
`timescale 1ns/1ps
module wake_timer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned WAKE_CYC = WAKE_MIN_CYC,
    parameter int unsigned OFF_CYC  = OFF_PULSE_CYC
) (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    wake_if.meas      wk
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             low_d_r;
    logic             low_d_nxt;

    // Count how long the pin has stayed low, saturating at the wake minimum
    always_comb begin
        low_d_nxt = wk.pin_low;
        cnt_nxt   = cnt_r;
        if (!wk.pin_low) begin
            cnt_nxt = '0;
        end else if (cnt_r < CNT_W'(WAKE_CYC)) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cnt_r   <= '0;
            low_d_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            low_d_r <= low_d_nxt;
        end
    end

    assign wk.long_low = (cnt_r >= CNT_W'(WAKE_CYC));
    assign wk.off_low  = (cnt_r >= CNT_W'(OFF_CYC));
    assign wk.released = low_d_r && !wk.pin_low;
    assign wk.was_long = (cnt_r >= CNT_W'(WAKE_CYC));

endmodule

// ==== hw/modem_power_state_sequencer.sv ====
// Power-state sequencer: off, on, sleep, deep sleep and shutdown paths
`timescale 1ns/1ps
module modem_power_state_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned WAKE_CYC   = WAKE_MIN_CYC,
    parameter int unsigned GRACE_CYC  = GRACE_MIN_CYC,
    parameter int unsigned OFF_CYC    = OFF_PULSE_CYC,
    parameter int unsigned PERIOD_CYC = SLEEP_PERIOD_CYC,
    parameter int unsigned ON_CYC     = SLEEP_ON_CYC
) (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic VBATT_OK,
    input  wire logic ON_OFF_WAKE_N,
    input  wire logic FAST_PIN,
    input  wire logic FAST_PIN_EN,
    input  wire logic POWER_ON_REQ,
    input  wire logic SHUTDOWN_CMD,
    input  wire logic SYSTEM_HALT_CMD,
    input  wire logic FAST_SHUTDOWN_CMD,
    input  wire logic POWER_SAVING_ENABLE_CMD,
    input  wire logic POWER_SAVING_DISABLE_CMD,
    input  wire logic SLEEP_REQ,
    input  wire logic HOST_CMD,
    input  wire logic UPDATE_TIMER_EXPIRED,
    input  wire logic SCHEDULED_WAKE,
    input  wire logic IDLE_DONE,
    output logic      POWER_ON_INDICATOR,
    output logic      BASEBAND_ON,
    output logic      RTC_RUN,
    output logic      CPU_ON,
    output logic      CMD_ACCEPT,
    output logic      NET_DETACH,
    output logic      FS_CLOSE,
    output logic      HALTED,
    output logic      FAST_ACTIVE,
    output logic [2:0] STATE
);

    // Refuse timing values that the counters cannot serve
    initial begin
        if (WAKE_CYC < 2 || OFF_CYC < 1 || OFF_CYC > WAKE_CYC ||
            GRACE_CYC < 2 || ON_CYC < 1 || ON_CYC >= PERIOD_CYC) begin
            $error("modem_power_state_sequencer: bad timing parameters");
        end
    end

    // Two-flop synchronisers for the pins; only the second stage is read
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s1_nxt;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s2_nxt;
    logic       fast_d_r;
    logic       fast_d_nxt;

    // Next values: shift the pins through both stages
    always_comb begin
        pin_s1_nxt = {VBATT_OK, FAST_PIN, ON_OFF_WAKE_N};
        pin_s2_nxt = pin_s1_r;
        fast_d_nxt = pin_s2_r[1];
    end

    // Reset to the idle-high levels so no false edge follows reset
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pin_s1_r <= 3'h7;
            pin_s2_r <= 3'h7;
            fast_d_r <= 1'b1;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            fast_d_r <= fast_d_nxt;
        end
    end

    logic vbatt_s;
    logic wake_n_s;
    logic fast_fall;

    assign vbatt_s   = pin_s2_r[2];
    assign wake_n_s  = pin_s2_r[0];
    // falling edge trigger
    // Edge counts only while the input is configured for fast shutdown
    assign fast_fall = FAST_PIN_EN && fast_d_r && !pin_s2_r[1];

    // Wake pin low-time meter
    wake_if wk ();
    assign wk.pin_low = !wake_n_s;

    wake_timer #(
        .WAKE_CYC (WAKE_CYC),
        .OFF_CYC  (OFF_CYC)
    ) u_wake (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .wk      (wk)
    );

    // Sequencer state
    pwr_state_type    st_r;
    pwr_state_type    st_nxt;
    logic [CNT_W-1:0] tmr_r;
    logic [CNT_W-1:0] tmr_nxt;
    logic             psm_en_r;
    logic             psm_en_nxt;
    logic             pend_r;
    logic             pend_nxt;
    // Set on a pin wake so the same held low phase cannot also halt
    logic             hold_r;
    logic             hold_nxt;

    // Pulsed processor enable in sleep
    function automatic logic duty_on(input logic [CNT_W-1:0] t);
        duty_on = (t < CNT_W'(ON_CYC));
    endfunction

    // Next state and timers
    always_comb begin
        // Timer runs freely; states that time something zero it on entry
        st_nxt     = st_r;
        tmr_nxt    = tmr_r + CNT_W'(1);
        psm_en_nxt = psm_en_r;
        pend_nxt   = pend_r;
        // Hold lasts only while the waking low phase goes on
        hold_nxt   = hold_r && wk.pin_low;
        if (POWER_SAVING_ENABLE_CMD) begin
            psm_en_nxt = 1'b1;
        end else if (POWER_SAVING_DISABLE_CMD) begin
            psm_en_nxt = 1'b0;
        end
        case (st_r)
            ST_OFF: begin
                // Timed work restarts from zero at the next power-on
                tmr_nxt  = '0;
                pend_nxt = 1'b0;
                if (POWER_ON_REQ && vbatt_s) begin
                    st_nxt = ST_ON;
                end
            end
            ST_ON, ST_SLEEP: begin
                // Wrap the duty-cycle timer once per sleep period
                if (st_r == ST_SLEEP && tmr_r >= CNT_W'(PERIOD_CYC - 1)) begin
                    tmr_nxt = '0;
                end
                // Priority: fast, halt, graceful, deep sleep, sleep moves
                if (FAST_SHUTDOWN_CMD || fast_fall) begin
                    st_nxt = ST_FAST;
                end else if (SYSTEM_HALT_CMD ||
                             (wk.long_low && !hold_r &&
                              !UPDATE_TIMER_EXPIRED)) begin
                    st_nxt  = ST_HALT;
                end else if (SHUTDOWN_CMD || (wk.released && !wk.was_long &&
                             pend_r)) begin
                    st_nxt  = ST_GRACE;
                    tmr_nxt = '0;
                end else if (UPDATE_TIMER_EXPIRED && psm_en_r) begin
                    st_nxt = ST_PSM;
                end else if (st_r == ST_ON && SLEEP_REQ) begin
                    st_nxt  = ST_SLEEP;
                    tmr_nxt = '0;
                end else if (st_r == ST_SLEEP && HOST_CMD) begin
                    st_nxt = ST_ON;
                end
                // Release ends the pulse and clears the mark in on and sleep; off always clears it, and the other states leave it as it was
                pend_nxt = wk.released ? 1'b0 : (wk.off_low ? 1'b1 : pend_r);
            end
            ST_PSM: begin
                tmr_nxt = '0;
                if (wk.long_low || SCHEDULED_WAKE) begin
                    st_nxt   = ST_ON;
                    // Waking pulse is not reused as a halt request
                    hold_nxt = wk.long_low;
                end
            end
            ST_GRACE: begin
                if (tmr_r >= CNT_W'(GRACE_CYC - 1) && IDLE_DONE) begin
                    st_nxt = ST_OFF;
                end else if (FAST_SHUTDOWN_CMD || fast_fall) begin
                    // A fast request may cut a slow graceful off short
                    st_nxt = ST_FAST;
                end
            end
            ST_HALT: begin
                if (!wk.pin_low && !SYSTEM_HALT_CMD && wake_n_s) begin
                    st_nxt = ST_OFF;
                end
            end
            ST_FAST: begin
                // One cycle to close files, then power off
                st_nxt = ST_OFF;
            end
            default: begin
                st_nxt = ST_OFF;
            end
        endcase
        // Supply loss drops everything to off
        if (!vbatt_s) begin
            st_nxt     = ST_OFF;
            psm_en_nxt = 1'b0;
        end
    end

    // Register the sequencer state
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r     <= ST_OFF;
            tmr_r    <= '0;
            psm_en_r <= 1'b0;
            pend_r   <= 1'b0;
            hold_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            tmr_r    <= tmr_nxt;
            psm_en_r <= psm_en_nxt;
            pend_r   <= pend_nxt;
            hold_r   <= hold_nxt;
        end
    end

    // Registered outputs derived from next state, except RTC_RUN from the supply
    logic       ind_nxt;
    logic       bb_nxt;
    logic       rtc_nxt;
    logic       cpu_nxt;
    logic       acc_nxt;
    logic       det_nxt;
    logic       fs_nxt;
    logic       halt_nxt;
    logic       fast_nxt;

    always_comb begin
        ind_nxt  = (st_nxt != ST_OFF) && (st_nxt != ST_PSM) &&
                   (st_nxt != ST_HALT);
        // Baseband down in off, deep sleep, halt and fast
        bb_nxt   = (st_nxt == ST_ON) || (st_nxt == ST_GRACE) ||
                   (st_nxt == ST_SLEEP);
        rtc_nxt  = vbatt_s;
        cpu_nxt  = (st_nxt == ST_ON) || (st_nxt == ST_GRACE) ||
                   ((st_nxt == ST_SLEEP) && duty_on(tmr_nxt));
        acc_nxt  = (st_nxt == ST_ON) || (st_nxt == ST_SLEEP);
        det_nxt  = (st_nxt == ST_GRACE);
        fs_nxt   = (st_nxt == ST_GRACE) || (st_nxt == ST_FAST);
        halt_nxt = (st_nxt == ST_HALT);
        fast_nxt = (st_nxt == ST_FAST);
    end

    // Every output comes straight from a flop
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            POWER_ON_INDICATOR <= 1'b0;
            BASEBAND_ON        <= 1'b0;
            RTC_RUN            <= 1'b0;
            CPU_ON             <= 1'b0;
            CMD_ACCEPT         <= 1'b0;
            NET_DETACH         <= 1'b0;
            FS_CLOSE           <= 1'b0;
            HALTED             <= 1'b0;
            FAST_ACTIVE        <= 1'b0;
            STATE              <= 3'h0;
        end else begin
            POWER_ON_INDICATOR <= ind_nxt;
            BASEBAND_ON        <= bb_nxt;
            RTC_RUN            <= rtc_nxt;
            CPU_ON             <= cpu_nxt;
            CMD_ACCEPT         <= acc_nxt;
            NET_DETACH         <= det_nxt;
            FS_CLOSE           <= fs_nxt;
            HALTED             <= halt_nxt;
            FAST_ACTIVE        <= fast_nxt;
            STATE              <= st_nxt;
        end
    end

endmodule

// ==== dv/pwr_seq_monitor.sv ====
// Checker for the power-state sequencer ports
`timescale 1ns/1ps
module pwr_seq_monitor
    import pwr_seq_pkg::*;
#(
    parameter int unsigned GRACE_CYC = GRACE_MIN_CYC
) (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       VBATT_OK,
    input wire logic       FAST_SHUTDOWN_CMD,
    input wire logic       SCHEDULED_WAKE,
    input wire logic       POWER_ON_INDICATOR,
    input wire logic       BASEBAND_ON,
    input wire logic       RTC_RUN,
    input wire logic       CPU_ON,
    input wire logic       CMD_ACCEPT,
    input wire logic       NET_DETACH,
    input wire logic       FS_CLOSE,
    input wire logic       HALTED,
    input wire logic [2:0] STATE
);
    logic [31:0] grace_cnt_r;
    logic [31:0] grace_cnt_nxt;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Cycles spent so far in graceful power-off
    always_comb begin
        grace_cnt_nxt = 32'h0000_0000;
        if (!RST && STATE == 3'h6) begin
            grace_cnt_nxt = grace_cnt_r + 32'h0000_0001;
        end
    end

    // Register the graceful cycle count
    always_ff @(posedge CLK_SYS) begin
        grace_cnt_r <= grace_cnt_nxt;
    end

    a_ind_powered: assert property (
        (STATE == 3'h1 || STATE == 3'h3) |-> POWER_ON_INDICATOR)
        else $error("indicator low while powered");
    a_ind_psm: assert property (STATE == 3'h2 |-> !POWER_ON_INDICATOR)
        else $error("indicator high in power saving");
    a_off_quiet: assert property (
        STATE == 3'h0 |-> !BASEBAND_ON && !CPU_ON)
        else $error("baseband active while off");
    a_off_exit: assert property (
        STATE == 3'h0 |=> STATE inside {3'h0, 3'h1})
        else $error("off left to a state other than on");
    a_sleep_cmd: assert property (STATE == 3'h3 |-> CMD_ACCEPT)
        else $error("commands refused in sleep");
    a_rtc_psm: assert property (STATE == 3'h2 |-> RTC_RUN)
        else $error("clock stopped in power saving");
    a_sched_wake: assert property (
        STATE == 3'h2 && SCHEDULED_WAKE && VBATT_OK |=> STATE == 3'h1)
        else $error("scheduled wake missed");
    a_grace_detach: assert property (
        STATE == 3'h6 |-> NET_DETACH && FS_CLOSE)
        else $error("graceful off without detach");
    a_grace_long: assert property (
        disable iff (RST || !VBATT_OK)
        STATE == 3'h6 && grace_cnt_r < GRACE_CYC - 1 |=> STATE == 3'h6)
        else $error("graceful off too short");
    a_halt_nodetach: assert property (
        STATE == 3'h7 |-> HALTED && !NET_DETACH && !POWER_ON_INDICATOR)
        else $error("halt shows detach or indicator");
    a_fast_cmd: assert property (
        (STATE == 3'h1 || STATE == 3'h3) && FAST_SHUTDOWN_CMD && VBATT_OK
        |=> STATE == 3'h5 ##1 STATE == 3'h0)
        else $error("fast command not honoured");

    c_power_on: cover property (STATE == 3'h0 ##1 STATE == 3'h1);
    c_psm_wake: cover property (STATE == 3'h2 ##1 STATE == 3'h1);
    c_grace_off: cover property (STATE == 3'h6 ##1 STATE == 3'h0);
endmodule

// ==== dv/host_pin_model.sv ====
// Host model driving the wake pin and fast-shutdown input
`timescale 1ns/1ps
module host_pin_model (
    output logic wake_n,
    output logic fast_pin
);
    // Both pins idle high
    initial begin
        wake_n = 1'b1;
        fast_pin = 1'b1;
    end

    // host drives the wake pin to the given level; caller times the low phase
    task drive_wake(input logic v);
        wake_n = v;
    endtask

    // Level of the fast-shutdown input
    task drive_fast(input logic v);
        fast_pin = v;
    endtask
endmodule

// ==== dv/modem_power_state_sequencer_test.sv ====
// Self-checking bench for the power-state sequencer
`timescale 1ns/1ps
module modem_power_state_sequencer_test
    import pwr_seq_pkg::*;
;
    localparam int POR = 0, SHD = 1, HLT = 2, FCM = 3, PSE = 4;
    localparam int PSD = 5, SLP = 6, HCM = 7, UPD = 8, SWK = 9;
    logic       clk = 1'b0;
    logic       rst, vbatt, fast_en, idle;
    logic       por_req, shd_req, sys_halt, fast_cmd, pse_req;
    logic       psd_req, slp_req, host_req, upd_exp, sched_wk;
    logic       wake_n, fast_pin, ind, bb, rtc, cpu, acc, det, fsc, hlt, fact;
    logic [2:0] state;
    int         n_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n;
    int         hi;

    host_pin_model host (.wake_n(wake_n), .fast_pin(fast_pin));

    modem_power_state_sequencer #(.WAKE_CYC(40), .OFF_CYC(10),
        .GRACE_CYC(8), .PERIOD_CYC(10), .ON_CYC(3)) dut (
        .CLK_SYS(clk), .RST(rst), .VBATT_OK(vbatt), .ON_OFF_WAKE_N(wake_n),
        .FAST_PIN(fast_pin), .FAST_PIN_EN(fast_en), .POWER_ON_REQ(por_req),
        .SHUTDOWN_CMD(shd_req), .SYSTEM_HALT_CMD(sys_halt),
        .FAST_SHUTDOWN_CMD(fast_cmd), .POWER_SAVING_ENABLE_CMD(pse_req),
        .POWER_SAVING_DISABLE_CMD(psd_req), .SLEEP_REQ(slp_req),
        .HOST_CMD(host_req), .UPDATE_TIMER_EXPIRED(upd_exp),
        .SCHEDULED_WAKE(sched_wk), .IDLE_DONE(idle),
        .POWER_ON_INDICATOR(ind), .BASEBAND_ON(bb), .RTC_RUN(rtc),
        .CPU_ON(cpu), .CMD_ACCEPT(acc), .NET_DETACH(det), .FS_CLOSE(fsc),
        .HALTED(hlt), .FAST_ACTIVE(fact), .STATE(state));

    // Clock and run-length guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            test_done();
        end
    end

    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // Level of one command input, picked by its code
    task set_cmd(input int k, input logic v);
        case (k)
            POR: por_req = v;
            SHD: shd_req = v;
            HLT: sys_halt = v;
            FCM: fast_cmd = v;
            PSE: pse_req = v;
            PSD: psd_req = v;
            SLP: slp_req = v;
            HCM: host_req = v;
            UPD: upd_exp = v;
            default: sched_wk = v;
        endcase
    endtask

    // One-cycle command pulse
    task cmd(input int k);
        set_cmd(k, 1'b1);
        step(1);
        set_cmd(k, 1'b0);
    endtask

    task wait_st(input logic [2:0] s, input int lim);
        n = 0;
        while (state !== s && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task t_off_on;
        step(3);
        check(rtc, 1);
        check(bb, 0);
        cmd(SHD);
        step(1);
        check(state, 0);
        cmd(POR);
        check(state, 1);
        check(ind, 1);
        step(1);
        cmd(PSD);
        step(1);
        check(ind, 1);
    endtask

    task t_sleep;
        cmd(SLP);
        check(acc, 1);
        hi = 0;
        repeat (20) begin
            step(1);
            hi += int'(cpu === 1'b1);
        end
        check(hi > 0 && hi < 20, 1);
        cmd(HCM);
        check(state, 1);
    endtask

    task t_psm;
        cmd(UPD);
        step(1);
        check(state, 1);
        cmd(PSE);
        step(1);
        cmd(UPD);
        check(state, 2);
        check(ind, 0);
        host.drive_wake(1'b0);
        step(20);
        host.drive_wake(1'b1);
        step(4);
        check(state, 2);
        host.drive_wake(1'b0);
        wait_st(1, 60);
        host.drive_wake(1'b1);
        check(n >= 40, 1);
        step(4);
        check(state, 1);
        cmd(UPD);
        step(1);
        cmd(SWK);
        check(state, 1);
    endtask

    task t_grace;
        idle = 1'b1;
        cmd(SHD);
        check(det, 1);
        check(fsc, 1);
        wait_st(0, 40);
        check(n >= 8, 1);
        cmd(POR);
        host.drive_wake(1'b0);
        step(20);
        host.drive_wake(1'b1);
        wait_st(6, 8);
        check(state, 6);
        wait_st(0, 40);
    endtask

    task t_halt;
        cmd(POR);
        host.drive_wake(1'b0);
        wait_st(7, 60);
        check(hlt, 1);
        host.drive_wake(1'b1);
        wait_st(0, 10);
        check(state, 0);
        cmd(POR);
        step(1);
        cmd(HLT);
        check(state, 7);
        vbatt = 1'b0;
        step(5);
        check(rtc, 0);
        vbatt = 1'b1;
        step(3);
    endtask

    task t_fast;
        cmd(POR);
        step(1);
        cmd(FCM);
        check(state, 5);
        step(1);
        cmd(POR);
        host.drive_fast(1'b0);
        step(5);
        check(state, 1);
        host.drive_fast(1'b1);
        fast_en = 1'b1;
        step(3);
        host.drive_fast(1'b0);
        wait_st(5, 6);
        check(fact, 1);
        step(3);
        host.drive_fast(1'b1);
    endtask

    task test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset, then every scenario in turn
    initial begin
        rst = 1'b1;
        vbatt = 1'b1;
        fast_en = 1'b0;
        idle = 1'b0;
        for (int k = 0; k < 10; k++) begin
            set_cmd(k, 1'b0);
        end
        step(20);
        rst = 1'b0;
        check(state, 0);
        t_off_on();
        t_sleep();
        t_psm();
        t_grace();
        t_halt();
        t_fast();
        test_done();
    end
endmodule

bind modem_power_state_sequencer pwr_seq_monitor #(.GRACE_CYC(GRACE_CYC)) mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .VBATT_OK(VBATT_OK),
    .FAST_SHUTDOWN_CMD(FAST_SHUTDOWN_CMD), .SCHEDULED_WAKE(SCHEDULED_WAKE),
    .POWER_ON_INDICATOR(POWER_ON_INDICATOR), .BASEBAND_ON(BASEBAND_ON),
    .RTC_RUN(RTC_RUN), .CPU_ON(CPU_ON), .CMD_ACCEPT(CMD_ACCEPT),
    .NET_DETACH(NET_DETACH), .FS_CLOSE(FS_CLOSE), .HALTED(HALTED),
    .STATE(STATE));
